//--- hw/ecp_defs.svh
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define ECP_NUM_CNT 24
`define ECP_NUM_EVT 32
`define ECP_NUM_EXT 24
`define ECP_NUM_AHB 8
`define ECP_NUM_CORE 4
`define ECP_SEL_W 5
`define ECP_CNT_W 32
`define ECP_ADDR_W 12
`define ECP_ROUTE_W 128

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ECP_OFF_BASE 12'h000
`define ECP_OFF_CNT_FIRST 12'h004
`define ECP_OFF_CNT_LAST 12'h060
`define ECP_OFF_OVF_MASK 12'h064
`define ECP_OFF_OVF_VEC 12'h068
`define ECP_OFF_ROUTE0 12'h0AC
`define ECP_OFF_ROUTE1 12'h0B0
`define ECP_OFF_ROUTE2 12'h0B4
`define ECP_OFF_ROUTE3 12'h0B8

// ----------------------------------------
// Base configuration fields
// ----------------------------------------
`define ECP_BIT_CNT_EN 0
`define ECP_BIT_CNT_RST 1
`define ECP_BIT_OVF_EN 2
`define ECP_BIT_OVF_RST 3
`define ECP_BIT_QUOTA_EN 4
`define ECP_BIT_QUOTA_RST 5
`define ECP_TEST_LSB 6
`define ECP_TEST_MSB 7
`define ECP_BASE_RESET 32'h00000000
`define ECP_BASE_MASK 32'h000000FF

// ----------------------------------------
// Reset values and counter maximum
// ----------------------------------------
`define ECP_CNT_RESET 32'h00000000
`define ECP_CNT_MAX 32'hFFFFFFFF
`define ECP_MASK_RESET 24'h000000
`define ECP_ROUTE_RESET 128'h0

`endif

//--- hw/ecp_pkg.sv
`include "ecp_defs.svh"

package ecp_pkg;
  typedef logic [31:0] ecp_word_t;
  typedef logic [`ECP_ADDR_W-1:0] ecp_addr_t;
  typedef logic [`ECP_NUM_EXT-1:0] ecp_ext_t;
  typedef logic [`ECP_NUM_CNT-1:0] ecp_cnt_vec_t;
  typedef logic [`ECP_NUM_EVT-1:0] ecp_evt_vec_t;
  typedef logic [`ECP_ROUTE_W-1:0] ecp_route_t;
  typedef logic [`ECP_SEL_W-1:0] ecp_sel_t;
  typedef enum logic [1:0] {
    ECP_TEST_OFF,
    ECP_TEST_ALL_ONE,
    ECP_TEST_ALL_ZERO,
    ECP_TEST_FIRST_ONE
  } ecp_test_t;
endpackage

//--- hw/ecp_route_if.sv
interface ecp_route_if;
  import ecp_pkg::*;
  logic clk;
  logic rst_n;
  ecp_evt_vec_t events;
  ecp_route_t route_bits;
  ecp_test_t test_mode;
  ecp_cnt_vec_t routed;
  modport ctrl (output clk, output rst_n, output events, output route_bits, output test_mode, input routed);
  modport xbar (input clk, input rst_n, input events, input route_bits, input test_mode, output routed);
endinterface

//--- hw/ecp_event_router.sv
`include "ecp_defs.svh"

module ecp_event_router (
  ecp_route_if.xbar rif
);
  import ecp_pkg::*;

  // ----------------------------------------
  // Per-counter input pick
  // ----------------------------------------
  function automatic logic pick(input ecp_test_t mode, input ecp_evt_vec_t ev, input ecp_sel_t sel,
                                input logic first);
    case (mode)
      ECP_TEST_OFF: pick = ev[sel];
      ECP_TEST_ALL_ONE: pick = 1'b1;
      ECP_TEST_ALL_ZERO: pick = 1'b0;
      ECP_TEST_FIRST_ONE: pick = first;
      default: pick = 1'b0;
    endcase
  endfunction

  for (genvar n = 0; n < `ECP_NUM_CNT; n++) begin : g_out
    // Field n feeds counter n
    assign rif.routed[n] = pick(rif.test_mode, rif.events, rif.route_bits[`ECP_SEL_W*n +: `ECP_SEL_W],
                                (n == 0));

    route_follow_a: assert property (@(posedge rif.clk) disable iff (!rif.rst_n)
      rif.test_mode == ECP_TEST_OFF |->
      rif.routed[n] == rif.events[rif.route_bits[`ECP_SEL_W*n +: `ECP_SEL_W]])
      else $error("routed input does not follow its selection field");
  end

  test_ones_a: assert property (@(posedge rif.clk) disable iff (!rif.rst_n)
    rif.test_mode == ECP_TEST_ALL_ONE |-> &rif.routed)
    else $error("all-ones pattern not applied");

  test_zero_a: assert property (@(posedge rif.clk) disable iff (!rif.rst_n)
    rif.test_mode == ECP_TEST_ALL_ZERO |-> rif.routed == '0)
    else $error("all-zeros pattern not applied");

  test_first_a: assert property (@(posedge rif.clk) disable iff (!rif.rst_n)
    rif.test_mode == ECP_TEST_FIRST_ONE |-> rif.routed == ecp_cnt_vec_t'(1))
    else $error("first-only pattern not applied");
endmodule

//--- hw/ecp_event_counter.sv
`include "ecp_defs.svh"

module ecp_event_counter (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire ecp_pkg::ecp_addr_t paddr,
  input wire ecp_pkg::ecp_word_t pwdata,
  output ecp_pkg::ecp_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [1:0] hmaster,
  output logic hreadyout,
  output logic hresp,
  input wire ecp_pkg::ecp_ext_t ext_events,
  output logic irq_ovf
);
  import ecp_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n_s;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_s <= rst_meta;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_s);

  // ----------------------------------------
  // Address decoding
  // ----------------------------------------
  function automatic logic is_cnt(input ecp_addr_t a);
    is_cnt = (a >= `ECP_OFF_CNT_FIRST) && (a <= `ECP_OFF_CNT_LAST);
  endfunction

  function automatic logic [4:0] cnt_slot(input ecp_addr_t a);
    ecp_addr_t d;
    d = a - `ECP_OFF_CNT_FIRST;
    cnt_slot = d[6:2];
  endfunction

  function automatic logic is_route(input ecp_addr_t a);
    is_route = (a >= `ECP_OFF_ROUTE0) && (a <= `ECP_OFF_ROUTE3);
  endfunction

  function automatic logic [1:0] route_slot(input ecp_addr_t a);
    ecp_addr_t d;
    d = a - `ECP_OFF_ROUTE0;
    route_slot = d[3:2];
  endfunction

  ecp_addr_t waddr;
  logic wr;
  logic setup;

  assign waddr = {paddr[`ECP_ADDR_W-1:2], 2'b00};
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  ecp_word_t base;
  ecp_cnt_vec_t ovf_mask;
  ecp_cnt_vec_t ovf_vec;
  ecp_route_t route;
  ecp_word_t count [`ECP_NUM_CNT];
  ecp_word_t next_base;
  ecp_cnt_vec_t next_ovf_mask;
  ecp_cnt_vec_t next_ovf_vec;
  ecp_route_t next_route;
  ecp_word_t next_count [`ECP_NUM_CNT];
  logic next_irq_ovf;

  logic cnt_on;
  logic cnt_rst;
  logic ovf_on;
  logic ovf_rst;
  ecp_test_t test_mode;

  assign cnt_on = base[`ECP_BIT_CNT_EN];
  assign cnt_rst = base[`ECP_BIT_CNT_RST];
  assign ovf_on = base[`ECP_BIT_OVF_EN];
  assign ovf_rst = base[`ECP_BIT_OVF_RST];
  assign test_mode = ecp_test_t'(base[`ECP_TEST_MSB:`ECP_TEST_LSB]);

  // ----------------------------------------
  // Bus snoop
  // ----------------------------------------
  logic [`ECP_NUM_AHB-1:0] ahb_evt;
  logic [`ECP_NUM_AHB-1:0] next_ahb_evt;

  always_comb begin
    for (int c = 0; c < `ECP_NUM_CORE; c++) begin
      next_ahb_evt[2*c] = hsel && htrans[1] && hready && (hmaster == 2'(c));
      next_ahb_evt[2*c+1] = hsel && htrans[1] && !hready && (hmaster == 2'(c));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ahb_evt <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ahb_evt <= next_ahb_evt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Crossbar and self-test
  // ----------------------------------------
  ecp_route_if rif ();

  assign rif.clk = core_clk;
  assign rif.rst_n = rst_n_s;
  assign rif.events = {ext_events, ahb_evt};
  assign rif.route_bits = route;
  assign rif.test_mode = test_mode;

  ecp_event_router u_router (
    .rif(rif.xbar)
  );

  // ----------------------------------------
  // Counter strobes
  // ----------------------------------------
  ecp_cnt_vec_t host_wr;
  ecp_cnt_vec_t inc;
  ecp_cnt_vec_t wrap;

  always_comb begin
    for (int k = 0; k < `ECP_NUM_CNT; k++) begin
      host_wr[k] = wr && is_cnt(waddr) && (cnt_slot(waddr) == 5'(k));
      inc[k] = cnt_on && !cnt_rst && !host_wr[k] && rif.routed[k];
      wrap[k] = inc[k] && (count[k] == `ECP_CNT_MAX);
    end
  end

  // ----------------------------------------
  // Register file next values
  // ----------------------------------------
  always_comb begin
    next_base = base;
    next_ovf_mask = ovf_mask;
    next_route = route;
    for (int k = 0; k < `ECP_NUM_CNT; k++) begin
      if (cnt_rst) begin
        next_count[k] = `ECP_CNT_RESET;
      end else if (host_wr[k]) begin
        next_count[k] = pwdata;
      end else if (inc[k]) begin
        next_count[k] = count[k] + 32'h00000001;
      end else begin
        next_count[k] = count[k];
      end
      // Set wins over the overflow reset
      next_ovf_vec[k] = (ovf_rst ? 1'b0 : ovf_vec[k]) | (wrap[k] && ovf_on && ovf_mask[k]);
    end
    if (wr) begin
      if (waddr == `ECP_OFF_BASE) begin
        next_base = pwdata & `ECP_BASE_MASK;
      end else if (waddr == `ECP_OFF_OVF_MASK) begin
        next_ovf_mask = pwdata[`ECP_NUM_CNT-1:0];
      end else if (is_route(waddr)) begin
        next_route[32*route_slot(waddr) +: 32] = pwdata;
      end
    end
    next_irq_ovf = |(next_ovf_vec & next_ovf_mask);
  end

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      base <= `ECP_BASE_RESET;
      ovf_mask <= `ECP_MASK_RESET;
      ovf_vec <= '0;
      route <= `ECP_ROUTE_RESET;
      irq_ovf <= 1'b0;
      for (int k = 0; k < `ECP_NUM_CNT; k++) begin
        count[k] <= `ECP_CNT_RESET;
      end
    end else begin
      base <= next_base;
      ovf_mask <= next_ovf_mask;
      ovf_vec <= next_ovf_vec;
      route <= next_route;
      irq_ovf <= next_irq_ovf;
      for (int k = 0; k < `ECP_NUM_CNT; k++) begin
        count[k] <= next_count[k];
      end
    end
  end

  // ----------------------------------------
  // APB read and handshake
  // ----------------------------------------
  ecp_word_t rd_probe;
  ecp_word_t next_prdata;
  logic next_pready;

  always_comb begin
    rd_probe = 32'h00000000;
    if (waddr == `ECP_OFF_BASE) begin
      rd_probe = base;
    end else if (is_cnt(waddr)) begin
      rd_probe = count[cnt_slot(waddr)];
    end else if (waddr == `ECP_OFF_OVF_MASK) begin
      rd_probe = {8'h00, ovf_mask};
    end else if (waddr == `ECP_OFF_OVF_VEC) begin
      rd_probe = {8'h00, ovf_vec};
    end else if (is_route(waddr)) begin
      rd_probe = route[32*route_slot(waddr) +: 32];
    end
  end

  always_comb begin
    next_pready = setup;
    next_prdata = prdata;
    if (setup && !pwrite) begin
      next_prdata = rd_probe;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic rd_unmapped;

  assign rd_unmapped = !is_cnt(waddr) && !is_route(waddr) && (waddr != `ECP_OFF_BASE) &&
                       (waddr != `ECP_OFF_OVF_MASK) && (waddr != `ECP_OFF_OVF_VEC);

  apb_ready_a: assert property (
    setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");

  unmapped_zero_a: assert property (
    setup && !pwrite && rd_unmapped |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");

  count_read_a: assert property (
    setup && !pwrite && is_cnt(waddr) |=> prdata == $past(rd_probe))
    else $error("counter read value wrong");

  irq_level_a: assert property (
    irq_ovf == |(ovf_vec & ovf_mask))
    else $error("interrupt does not match enabled vector bits");

  base_write_a: assert property (
    wr && waddr == `ECP_OFF_BASE |=> base == ($past(pwdata) & `ECP_BASE_MASK))
    else $error("base configuration write not stored");

  mask_write_a: assert property (
    wr && waddr == `ECP_OFF_OVF_MASK |=> ovf_mask == $past(pwdata[`ECP_NUM_CNT-1:0]))
    else $error("overflow mask write not stored");

  vec_readonly_a: assert property (
    wr && waddr == `ECP_OFF_OVF_VEC && !ovf_rst && wrap == '0 |=> ovf_vec == $past(ovf_vec))
    else $error("overflow vector changed by host write");

  snoop_count_a: assert property (
    hsel && htrans[1] && hmaster == 2'b00 |=> ahb_evt[0] == $past(hready) && ahb_evt[1] == !$past(hready))
    else $error("snooped beat not turned into event");

  for (genvar k = 0; k < `ECP_NUM_CNT; k++) begin : g_chk
    count_inc_a: assert property (
      cnt_on && !cnt_rst && !host_wr[k] && rif.routed[k] |=> count[k] == $past(count[k]) + 32'h00000001)
      else $error("counter did not increment");

    count_hold_a: assert property (
      !cnt_on && !cnt_rst && !host_wr[k] |=> count[k] == $past(count[k]))
      else $error("disabled counter changed");

    count_clear_a: assert property (
      cnt_rst |=> count[k] == `ECP_CNT_RESET)
      else $error("counter not cleared by reset field");

    count_load_a: assert property (
      host_wr[k] && !cnt_rst |=> count[k] == $past(pwdata))
      else $error("host value not loaded");

    ovf_set_a: assert property (
      ovf_on && ovf_mask[k] && inc[k] && count[k] == `ECP_CNT_MAX |=> ovf_vec[k] && count[k] == 32'h00000000)
      else $error("wrap did not set vector bit");

    ovf_sticky_a: assert property (
      ovf_vec[k] && !ovf_rst |=> ovf_vec[k])
      else $error("vector bit dropped without reset");

    ovf_masked_a: assert property (
      !ovf_mask[k] && !ovf_vec[k] |=> !ovf_vec[k])
      else $error("masked counter set vector bit");
  end
endmodule

//--- dv/ecp_snoop_partner.sv
module ecp_snoop_partner (
  input wire logic core_clk,
  output logic hsel,
  output logic [1:0] htrans,
  output logic hready,
  output logic [1:0] hmaster
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    htrans = 2'b00;
    hready = 1'b1;
    hmaster = 2'b00;
  end

  // ----------------------------------------
  // Accepted beats, then wait states
  // ----------------------------------------
  task automatic burst(input logic [1:0] core, input int n_ok, input int n_wait);
    for (int i = 0; i < n_ok + n_wait; i++) begin
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hready <= (i < n_ok);
      hmaster <= core;
    end
    @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hready <= 1'b1;
    hmaster <= ~core;
  endtask
endmodule

//--- dv/test_event_counter_pmu.sv
`include "ecp_defs.svh"
`define CHK(what, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
  end \
end

module test_event_counter_pmu;
  timeunit 1ns;
  timeprecision 1ps;
  import ecp_pkg::*;

  localparam ecp_word_t RUN = 32'h0000000D;
  localparam ecp_word_t ROUTES [4] = '{32'h50002020, 32'h00000042, 32'h00000000, 32'h00400000};
  logic core_clk;
  logic resetn;
  logic psel;
  logic penable;
  logic pwrite;
  ecp_addr_t paddr;
  ecp_word_t pwdata;
  ecp_word_t prdata;
  logic pready;
  logic pslverr;
  logic hsel;
  logic [1:0] htrans;
  logic hready;
  logic [1:0] hmaster;
  logic hreadyout;
  logic hresp;
  ecp_ext_t ext_events;
  logic irq_ovf;
  int mismatches;
  int n_compared;

  ecp_event_counter i_ecp_event_counter (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hmaster(hmaster), .hreadyout(hreadyout),
    .hresp(hresp), .ext_events(ext_events), .irq_ovf(irq_ovf)
  );

  ecp_snoop_partner i_ecp_snoop_partner (
    .core_clk(core_clk), .hsel(hsel), .htrans(htrans), .hready(hready), .hmaster(hmaster)
  );

  always #20 core_clk = ~core_clk;

  // ----------------------------------------
  // Closing and bus tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input ecp_addr_t addr, input ecp_word_t data, output ecp_word_t got);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (n >= 8) begin
      mismatches++;
      report_and_stop();
    end
    got = prdata;
    `CHK("pslverr", 1'b0, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input ecp_addr_t a, input ecp_word_t d);
    ecp_word_t unused;
    apb(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input string what, input ecp_addr_t a, input ecp_word_t exp);
    ecp_word_t got;
    apb(1'b0, a, 32'h00000000, got);
    `CHK(what, exp, got)
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ext_events = 24'h000000;
    mismatches = 0;
    n_compared = 0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd_chk("base", `ECP_OFF_BASE, 32'h00000000);
    rd_chk("mask", `ECP_OFF_OVF_MASK, 32'h00000000);
    rd_chk("vec", `ECP_OFF_OVF_VEC, 32'h00000000);
    rd_chk("count0", `ECP_OFF_CNT_FIRST, 32'h00000000);
    wr(`ECP_OFF_BASE, 32'h1234563C);
    rd_chk("base", `ECP_OFF_BASE, 32'h0000003C);
    wr(12'h0C0, 32'hFFFFFFFF);
    rd_chk("unmapped", 12'h0C0, 32'h00000000);
    for (int r = 0; r < 4; r++) begin
      wr(ecp_addr_t'(`ECP_OFF_ROUTE0 + 4 * r), ROUTES[r]);
      rd_chk("route", ecp_addr_t'(`ECP_OFF_ROUTE0 + 4 * r), ROUTES[r]);
    end
    ext_events <= 24'hFFFFFF;
    for (int m = 0; m < 4; m++) begin
      wr(`ECP_OFF_BASE, 32'h00000002);
      wr(`ECP_OFF_BASE, 32'h00000000);
      wr(`ECP_OFF_BASE, ecp_word_t'(32'h00000001 | (m << 6)));
      repeat (10) @(posedge core_clk);
      wr(`ECP_OFF_BASE, 32'h00000000);
      rd_chk("count0", 12'h004, (m == 1 || m == 3) ? RUN : 32'h00000000);
      rd_chk("count2", 12'h00C, (m < 2) ? RUN : 32'h00000000);
      rd_chk("count6", 12'h01C, (m < 2) ? RUN : 32'h00000000);
      rd_chk("count23", `ECP_OFF_CNT_LAST, (m < 2) ? RUN : 32'h00000000);
    end
    wr(12'h018, 32'hFFFFFFFE);
    wr(12'h020, 32'hFFFFFFFE);
    wr(`ECP_OFF_OVF_MASK, 32'h00000020);
    rd_chk("mask", `ECP_OFF_OVF_MASK, 32'h00000020);
    wr(`ECP_OFF_BASE, 32'h00000005);
    repeat (10) @(posedge core_clk);
    wr(`ECP_OFF_BASE, 32'h00000000);
    rd_chk("count5", 12'h018, 32'h0000000B);
    rd_chk("count7", 12'h020, 32'h0000000B);
    rd_chk("vec", `ECP_OFF_OVF_VEC, 32'h00000020);
    `CHK("irq_ovf", 1'b1, irq_ovf)
    wr(`ECP_OFF_OVF_VEC, 32'hFFFFFFFF);
    rd_chk("vec", `ECP_OFF_OVF_VEC, 32'h00000020);
    `CHK("irq_ovf", 1'b1, irq_ovf)
    wr(`ECP_OFF_BASE, 32'h00000008);
    wr(`ECP_OFF_BASE, 32'h00000000);
    rd_chk("vec", `ECP_OFF_OVF_VEC, 32'h00000000);
    `CHK("irq_ovf", 1'b0, irq_ovf)
    wr(`ECP_OFF_BASE, 32'h00000002);
    wr(`ECP_OFF_BASE, 32'h00000001);
    i_ecp_snoop_partner.burst(2'b01, 4, 2);
    i_ecp_snoop_partner.burst(2'b00, 5, 3);
    repeat (6) @(posedge core_clk);
    wr(`ECP_OFF_BASE, 32'h00000000);
    rd_chk("count0", 12'h004, 32'h00000005);
    rd_chk("count1", 12'h008, 32'h00000003);
    `CHK("hreadyout", 1'b1, hreadyout)
    `CHK("hresp", 1'b0, hresp)
    // ----------------------------------------
    // Reset in mid-run
    // ----------------------------------------
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("hreadyout", 1'b1, hreadyout)
    `CHK("pready", 1'b0, pready)
    `CHK("irq_ovf", 1'b0, irq_ovf)
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd_chk("base", `ECP_OFF_BASE, 32'h00000000);
    rd_chk("count0", `ECP_OFF_CNT_FIRST, 32'h00000000);
    rd_chk("route", `ECP_OFF_ROUTE3, 32'h00000000);
    report_and_stop();
  end
endmodule
